// *** core/usd_core.sv ***
// USART transmit and receive data path with a classic Wishbone slave.
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
module usd_core
    import usd_pkg::*;
#(
    parameter int RX_DEPTH = 2
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SRST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        SERIAL_CLOCK_PIN,
    input  wire logic        SERIAL_IN_PIN,
    output logic             SERIAL_OUT_PIN,
    output logic             SERIAL_OUT_OE,
    output logic             SERIAL_IN_OWNED,
    input  wire logic        TXC_IRQ_TAKEN,
    output logic             IRQ_TX_EMPTY,
    output logic             IRQ_TX_DONE,
    output logic             IRQ_RX_DONE
);
    localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_DATA = 2'b01,
        RX_PAR  = 2'b10,
        RX_STOP = 2'b11
    } usd_rx_state_t;

    function automatic logic [3:0] data_bits(input logic [2:0] size);
        case (size)
            3'h0:    data_bits = 4'h5;
            3'h1:    data_bits = 4'h6;
            3'h2:    data_bits = 4'h7;
            3'h7:    data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    function automatic logic parity(input logic [8:0] d,
                                    input logic [3:0] n,
                                    input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                p = p ^ d[i];
            end
        end
        parity = p;
    endfunction

    // Frame bits in send order, bit 0 first; unused tail is stop level.
    function automatic logic [USD_FRAME_W-1:0] make_frame(
        input logic [8:0] d, input usd_format_t f);
        logic [USD_FRAME_W-1:0] v;
        logic [3:0]             n;
        v = '1;
        n = data_bits(f.size);
        v[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                v[i+1] = d[i];
            end
        end
        if (f.pen) begin
            v[n+4'h1] = parity(d, n, f.podd);
        end
        make_frame = v;
    endfunction

    function automatic logic [3:0] frame_len(input usd_format_t f);
        frame_len = 4'h2 + data_bits(f.size) + {3'h0, f.pen}
                  + {3'h0, f.stop2};
    endfunction

    logic [7:0]    control_q;
    usd_format_t   format_q;
    logic          ack_q;
    logic [31:0]   rdata_q;
    logic          xck_s1_q, xck_s2_q, xck_s3_q;
    logic          rxd_s1_q, rxd_s2_q;
    logic          tx_full_q;
    logic [8:0]    tx_buf_q;
    logic          tx_busy_q;
    logic [USD_FRAME_W-1:0] tx_sh_q;
    logic [3:0]    tx_cnt_q;
    logic          tx_out_q;
    logic          tx_active_q;
    logic          txc_q;
    usd_rx_state_t rx_st_q;
    logic [3:0]    rx_idx_q;
    logic [8:0]    rx_sh_q;
    logic          rx_par_q;
    logic          rx_hold_q;
    logic          dor_pend_q;
    usd_rx_entry_t rx_held_q;
    usd_rx_entry_t fifo_q [RX_DEPTH];
    logic [PW-1:0] wr_ptr_q, rd_ptr_q;
    logic [PW:0]   count_q;

    logic          req, wr_ack, rd_ack;
    logic          sel_data, sel_status, sel_control, sel_format;
    logic          tx_rise, rx_fall;
    logic          data_wr, data_rd, frame_done;
    logic          push, pop, fifo_full, rx_done;
    logic [3:0]    nbits;
    usd_rx_entry_t head, new_entry;

    assign req         = WB_CYC_I & WB_STB_I;
    assign wr_ack      = req & ack_q & WB_WE_I & WB_SEL_I[0];
    assign rd_ack      = req & ack_q & ~WB_WE_I & WB_SEL_I[0];
    assign sel_status  = WB_ADR_I == USD_OFS_STATUS;
    assign sel_control = WB_ADR_I == USD_OFS_CONTROL;
    assign sel_format  = WB_ADR_I == USD_OFS_FORMAT;
    assign sel_data    = WB_ADR_I == USD_OFS_DATA;
    assign data_wr     = wr_ack & sel_data;
    assign data_rd     = rd_ack & sel_data;
    assign tx_rise     = xck_s2_q & ~xck_s3_q;
    assign rx_fall     = ~xck_s2_q & xck_s3_q;
    assign nbits       = data_bits(format_q.size);
    assign fifo_full   = count_q == (PW+1)'(RX_DEPTH);
    assign head        = fifo_q[rd_ptr_q];
    assign frame_done  = tx_busy_q & tx_rise & (tx_cnt_q == 4'h0);

    // Registered ack drops the cycle after it is given.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data is captured on the same edge that raises the ack.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rdata_q <= 32'h0;
        end else if (req & ~ack_q) begin
            rdata_q <= 32'h0;
            if (sel_status) begin
                // [R23] receive flag state
                rdata_q[USD_ST_RXC]  <= count_q != '0;
                rdata_q[USD_ST_TXC]  <= txc_q;
                // [R02] buffer empty flag
                rdata_q[USD_ST_UDRE] <= ~tx_full_q;
                // [R19] per entry status
                rdata_q[USD_ST_FE]   <= head.fe & (count_q != '0);
                rdata_q[USD_ST_DOR]  <= head.dor & (count_q != '0);
                rdata_q[USD_ST_UPE]  <= head.upe & (count_q != '0);
            end else if (sel_control) begin
                rdata_q[7:0] <= control_q;
                rdata_q[USD_CT_RXB8] <= head.b8 & (count_q != '0);
            end else if (sel_format) begin
                rdata_q[5:0] <= format_q;
            end else if (sel_data) begin
                rdata_q[7:0] <= (count_q != '0) ? head.data : 8'h00;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            control_q <= USD_CONTROL_RST;
            format_q  <= USD_FORMAT_RST;
        end else begin
            if (wr_ack & sel_control) begin
                control_q <= WB_DAT_I[7:0] & 8'hfd;
            end
            if (wr_ack & sel_format) begin
                format_q <= WB_DAT_I[5:0];
            end
        end
    end

    // Pins come from outside; second stages feed logic, and the clock pin's third stage feeds its edge detection.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            xck_s1_q <= 1'b0;
            xck_s2_q <= 1'b0;
            xck_s3_q <= 1'b0;
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
        end else begin
            xck_s1_q <= SERIAL_CLOCK_PIN;
            xck_s2_q <= xck_s1_q;
            xck_s3_q <= xck_s2_q;
            rxd_s1_q <= SERIAL_IN_PIN;
            rxd_s2_q <= rxd_s1_q;
        end
    end

    // [R05] data write fills the buffer
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            tx_full_q <= 1'b0;
            tx_buf_q  <= 9'h0;
        end else begin
            // [R21] buffer drains into the shift register
            if ((~tx_busy_q & tx_full_q) | (frame_done & tx_full_q)) begin
                tx_full_q <= 1'b0;
            end
            // [R01] ninth bit taken from control at data write
            if (data_wr & control_q[USD_CT_TRANSMIT_ENABLE_BIT]) begin
                tx_full_q <= 1'b1;
                tx_buf_q  <= {control_q[USD_CT_TX_NINTH_BIT], WB_DAT_I[7:0]};
            end
        end
    end

    // Data changes on the rising clock pin edge.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= '1;
            tx_cnt_q  <= 4'h0;
            tx_out_q  <= 1'b1;
        end else if (~tx_busy_q) begin
            // [R21] load when idle
            if (tx_full_q) begin
                tx_busy_q <= 1'b1;
                // [R20] [R22] frame built, upper bits masked
                tx_sh_q   <= make_frame(tx_buf_q, format_q);
                tx_cnt_q  <= frame_len(format_q);
            end
        end else if (frame_done) begin
            // [R21] back to back load after last stop
            if (tx_full_q) begin
                tx_sh_q  <= make_frame(tx_buf_q, format_q) >> 1;
                tx_cnt_q <= frame_len(format_q) - 4'h1;
                tx_out_q <= 1'b0;
            end else begin
                tx_busy_q <= 1'b0;
            end
        end else if (tx_rise) begin
            // [R09] parity sits inside the shifted frame
            tx_out_q <= tx_sh_q[0];
            tx_sh_q  <= {1'b1, tx_sh_q[USD_FRAME_W-1:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
        end
    end

    // [R10] disable only once idle and empty
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            tx_active_q <= 1'b0;
        end else if (control_q[USD_CT_TRANSMIT_ENABLE_BIT]) begin
            tx_active_q <= 1'b1;
        end else if (~tx_busy_q & ~tx_full_q) begin
            tx_active_q <= 1'b0;
        end
    end

    // [R06] [R07] set wins over both clears
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            txc_q <= 1'b0;
        end else if (frame_done & ~tx_full_q) begin
            txc_q <= 1'b1;
        end else if (TXC_IRQ_TAKEN |
                     (wr_ack & sel_status & WB_DAT_I[USD_ST_TXC])) begin
            txc_q <= 1'b0;
        end
    end

    // Received data is sampled on the falling clock pin edge.
    assign rx_done = rx_fall & (rx_st_q == RX_STOP);
    always_comb begin
        new_entry      = '0;
        new_entry.dor  = dor_pend_q;
        // [R17] unused bits zero
        new_entry.data = rx_sh_q[7:0];
        new_entry.b8   = rx_sh_q[8];
        new_entry.fe   = ~rxd_s2_q;
        new_entry.upe  = format_q.pen &
                         (parity(rx_sh_q, nbits, format_q.podd) != rx_par_q);
    end

    // [R12] [R13] [R14] receiver on the external clock
    always_ff @(posedge CLK_SYS) begin
        if (SRST | ~control_q[USD_CT_RXEN]) begin
            rx_st_q  <= RX_IDLE;
            rx_idx_q <= 4'h0;
            rx_sh_q  <= 9'h0;
            rx_par_q <= 1'b0;
        end else if (rx_fall) begin
            unique case (rx_st_q)
                RX_IDLE: begin
                    if (~rxd_s2_q) begin
                        rx_st_q  <= RX_DATA;
                        rx_idx_q <= 4'h0;
                        rx_sh_q  <= 9'h0;
                    end
                end
                RX_DATA: begin
                    rx_sh_q[rx_idx_q] <= rxd_s2_q;
                    rx_idx_q <= rx_idx_q + 4'h1;
                    if (rx_idx_q == nbits - 4'h1) begin
                        rx_st_q <= format_q.pen ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    rx_par_q <= rxd_s2_q;
                    rx_st_q  <= RX_STOP;
                end
                // [R15] first stop ends the frame
                RX_STOP: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // [R16] completed frame goes to the buffer or waits in hold
    assign pop  = data_rd & (count_q != '0);
    assign push = (rx_done & (~fifo_full | pop)) |
                  (rx_hold_q & ~rx_done & (~fifo_full | pop));

    always_ff @(posedge CLK_SYS) begin
        if (SRST | ~control_q[USD_CT_RXEN]) begin
            rx_hold_q  <= 1'b0;
            dor_pend_q <= 1'b0;
            rx_held_q  <= '0;
        end else begin
            if (rx_done & fifo_full & ~pop) begin
                rx_hold_q <= 1'b1;
                rx_held_q <= new_entry;
            end else if (push) begin
                rx_hold_q  <= 1'b0;
                dor_pend_q <= 1'b0;
            end
            // A start bit while a frame still waits loses data.
            if (rx_hold_q & ~push & rx_fall & (rx_st_q == RX_IDLE)
                & ~rxd_s2_q) begin
                dor_pend_q <= 1'b1;
            end
        end
    end

    // [R19] data read advances the status FIFO
    always_ff @(posedge CLK_SYS) begin
        if (SRST | ~control_q[USD_CT_RXEN]) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(RX_DEPTH-1)) ? '0
                          : wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(RX_DEPTH-1)) ? '0
                          : rd_ptr_q + PW'(1);
            end
            count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (push) begin
            fifo_q[wr_ptr_q] <= rx_hold_q ? rx_held_q : new_entry;
        end
    end

    assign WB_ACK_O        = ack_q;
    assign WB_DAT_O        = rdata_q;
    // [R11] pin released once disabled
    assign SERIAL_OUT_OE   = tx_active_q;
    assign SERIAL_OUT_PIN  = tx_out_q;
    // [R12] receiver owns the input pin
    assign SERIAL_IN_OWNED = control_q[USD_CT_RXEN];
    // [R04] [R08] [R24] request levels
    assign IRQ_TX_EMPTY    = ~tx_full_q & control_q[USD_CT_UDRIE];
    assign IRQ_TX_DONE     = txc_q & control_q[USD_CT_TXCIE];
    assign IRQ_RX_DONE     = (count_q != '0) & control_q[USD_CT_RXCIE];
endmodule // usd_core

// *** include/usd_pkg.sv ***
// Constants, field layouts and carrier types of the USART data path.
// Behaviour
// [R01] Software writes ninth bit before low byte.
// [R02] Empty flag high while transmit buffer empty.
// [R03] Software writes zero to empty flag.
// [R04] Empty request held while flag and enable.
// [R05] Data register write fills buffer, clears flag.
// [R06] Complete flag set when frame out, buffer empty.
// [R07] Complete flag cleared by acknowledge or one.
// [R08] Complete request raised when flag and enable.
// [R09] Parity inserted after data, before stop.
// [R10] Transmit disable waits for idle and empty.
// [R11] Disabled transmitter releases the data pin.
// [R12] Receive enable takes over serial input pin.
// [R13] Synchronous receiver uses external clock pin.
// [R14] Start bit begins reception, bits shifted in.
// [R15] Second stop bit ignored, first completes.
// [R16] First stop moves frame into receive buffer.
// [R17] Unused upper received bits read as zero.
// [R18] Software reads ninth bit, status first.
// [R19] Status per FIFO entry, data read advances.
// [R20] Unused upper transmit bits are ignored.
// [R21] Shift register loads when idle or frame ends.
// [R22] Start low, data LSB first, parity, stop high.
// [R23] Receive flag set while unread data buffered.
// [R24] Requests are flag AND enable levels.
package usd_pkg;
    localparam logic [7:0] USD_OFS_STATUS  = 8'h00;
    localparam logic [7:0] USD_OFS_CONTROL = 8'h04;
    localparam logic [7:0] USD_OFS_FORMAT  = 8'h08;
    localparam logic [7:0] USD_OFS_DATA    = 8'h0c;

    localparam int USD_ST_RXC  = 7;
    localparam int USD_ST_TXC  = 6;
    localparam int USD_ST_UDRE = 5;
    localparam int USD_ST_FE   = 4;
    localparam int USD_ST_DOR  = 3;
    localparam int USD_ST_UPE  = 2;

    localparam int USD_CT_RXCIE = 7;
    localparam int USD_CT_TXCIE = 6;
    localparam int USD_CT_UDRIE = 5;
    localparam int USD_CT_RXEN  = 4;
    localparam int USD_CT_TRANSMIT_ENABLE_BIT  = 3;
    localparam int USD_CT_RXB8  = 1;
    localparam int USD_CT_TX_NINTH_BIT  = 0;

    localparam int USD_FM_SIZE = 0;
    localparam int USD_FM_STOP = 3;
    localparam int USD_FM_PEN  = 5;
    localparam int USD_FM_PODD = 4;

    localparam logic [7:0] USD_CONTROL_RST = 8'h00;
    localparam logic [5:0] USD_FORMAT_RST  = 6'h03;
    localparam logic [2:0] USD_SIZE_NINE   = 3'h7;
    localparam int         USD_FRAME_W     = 13;

    typedef struct packed {
        logic       dor;
        logic       upe;
        logic       fe;
        logic       b8;
        logic [7:0] data;
    } usd_rx_entry_t;

    typedef struct packed {
        logic       pen;
        logic       podd;
        logic       stop2;
        logic [2:0] size;
    } usd_format_t;
endpackage

// *** test/testbench.sv ***
// Self-checking bench for the USART data path.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
    import usd_pkg::*;
    logic        clk, srst, cyc, we, taken, bs, bp;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rd, got, g, mk;
    logic [8:0]  a, b, r1, r2, x, dm;
    wire  [31:0] rdat;
    wire         ack, sdo, oe, own, irq_e, irq_d, irq_r, sck, sdi;
    usd_format_t f;
    int          errors = 0, n_tests = 0, len, off;
    usd_core dut (.CLK_SYS(clk), .SRST(srst), .WB_CYC_I(cyc),
        .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SERIAL_CLOCK_PIN(sck), .SERIAL_IN_PIN(sdi), .SERIAL_OUT_PIN(sdo),
        .SERIAL_OUT_OE(oe), .SERIAL_IN_OWNED(own), .TXC_IRQ_TAKEN(taken),
        .IRQ_TX_EMPTY(irq_e), .IRQ_TX_DONE(irq_d), .IRQ_RX_DONE(irq_r));
    usd_station st (.sck(sck), .sdi(sdi), .sdo(sdo));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic conclude;
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Ack is sampled at the rising edge where the write lands.
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        @(negedge clk);
    endtask
    function automatic int nbits(logic [2:0] s);
        return s < 3'h4 ? int'(s) + 5 : (s == USD_SIZE_NINE ? 9 : 8);
    endfunction
    function automatic logic [12:0] frame(logic [8:0] d, usd_format_t fm,
                                          logic bstop, logic bpar);
        int n;
        logic [12:0] v;
        logic [8:0] m;
        n = nbits(fm.size);
        m = d & ((9'h1 << n) - 9'h1);
        v = 13'h1fff;
        v[0] = 1'b0;
        for (int i = 0; i < n; i++) v[i + 1] = m[i];
        if (fm.pen) v[n + 1] = ^m ^ fm.podd ^ bpar;
        v[n + 1 + int'(fm.pen)] = ~bstop;
        return v;
    endfunction
    task automatic setf(usd_format_t fm);
        f = fm;
        len = nbits(fm.size) + 2 + int'(fm.pen) + int'(fm.stop2);
        mk = (32'h1 << len) - 32'h1;
        dm = (9'h1 << nbits(fm.size)) - 9'h1;
        wb(1'b1, USD_OFS_FORMAT, 32'(fm));
    endtask
    initial begin
        #400000;
        errors++;
        conclude;
    end
    initial begin
        {cyc, we, adr, wdat, taken} = '0;
        sel = 4'hf;
        srst = 1'b1;
        void'($urandom(53622));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        `CHK("oe_rst", 2'b01, {oe, sdo})
        wb(1'b0, USD_OFS_STATUS, 32'h0);
        `CHK("st_rst", 2'b01, {rd[7], rd[5]})
        @(posedge clk) sel <= 4'h0;
        wb(1'b1, USD_OFS_FORMAT, 32'h3f);
        @(posedge clk) sel <= 4'hf;
        wb(1'b0, USD_OFS_FORMAT, 32'h0);
        `CHK("fmt_rst", 32'(USD_FORMAT_RST), rd)
        wb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        wb(1'b1, USD_OFS_CONTROL, 32'hf8);
        @(negedge clk);
        `CHK("enable", 3'b111, {irq_e, own, oe})
        for (int it = 0; it < 12; it++) begin
            f = usd_format_t'(6'($urandom));
            f.size = (it % 5 == 4) ? USD_SIZE_NINE : 3'(it % 5);
            f.pen = 1'(it);
            f.podd = 1'(it >> 1);
            setf(f);
            {a, b, r1, r2} = {$urandom, $urandom};
            if (it == 0) {a, b} = {9'h1ff, 9'h000};
            bs = ($urandom % 4) == 0;
            bp = ($urandom % 4) == 0;
            wb(1'b1, USD_OFS_CONTROL, 32'hf8 | 32'(a[8]));
            wb(1'b1, USD_OFS_DATA, 32'(a));
            wb(1'b1, USD_OFS_CONTROL, 32'hf8 | 32'(b[8]));
            wb(1'b1, USD_OFS_DATA, 32'(b));
            wb(1'b0, USD_OFS_STATUS, 32'h0);
            `CHK("pending", 2'b00, {rd[5], irq_e})
            g = ~(mk | mk << len) | (32'(frame(r2, f, 1'b0, 1'b0)) & mk) << len
                | (32'(frame(r1, f, bs, bp)) & mk);
            st.run(g, 2 * len + 2, got);
            repeat (8) @(negedge clk);
            `CHK("tx1", 32'(frame(a, f, 1'b0, 1'b0)) & mk, got & mk)
            off = got[len] ? len + 1 : len;
            `CHK("tx2", 32'(frame(b, f, 1'b0, 1'b0)) & mk, (got >> off) & mk)
            wb(1'b0, USD_OFS_STATUS, 32'h0);
            `CHK("st_done", 3'b111, rd[7:5])
            `CHK("irqs", 3'b111, {irq_r, irq_d, irq_e})
            // status and ninth bit are read before data
            for (int k = 0; k < 2; k++) begin
                x = k ? r2 : r1;
                wb(1'b0, USD_OFS_STATUS, 32'h0);
                `CHK("rx_st", {1'b1, !k & bs, 1'b0, !k & bp & f.pen}, {rd[7], rd[4:2]})
                wb(1'b0, USD_OFS_CONTROL, 32'h0);
                if (f.size == USD_SIZE_NINE) `CHK("rx8", x[8], rd[1])
                wb(1'b0, USD_OFS_DATA, 32'h0);
                `CHK("rx_d", {24'h0, x[7:0] & dm[7:0]}, rd)
            end
            wb(1'b0, USD_OFS_STATUS, 32'h0);
            `CHK("rx_empty", 1'b0, rd[7])
            if (it % 2) begin
                @(posedge clk) taken <= 1'b1;
                @(posedge clk) taken <= 1'b0;
                @(negedge clk);
            end else begin
                wb(1'b1, USD_OFS_STATUS, 32'h40);
            end
            `CHK("txc_clr", 1'b0, irq_d)
        end
        // Two frames buffered, one held, a fourth start overruns.
        setf(usd_format_t'(6'h00));
        for (int j = 0; j < 4; j++) begin
            st.run(~mk | 32'(frame(9'(j + 5), f, 1'b0, 1'b0)), len, got);
        end
        for (int j = 0; j < 3; j++) begin
            wb(1'b0, USD_OFS_STATUS, 32'h0);
            `CHK("dor", j == 2, rd[3])
            wb(1'b0, USD_OFS_DATA, 32'h0);
            `CHK("dor_d", 32'(j == 2 ? 8 : j + 5), rd)
        end
        setf(usd_format_t'(6'h03));
        st.run(~mk | 32'(frame(9'h0a5, f, 1'b0, 1'b0)), len + 1, got);
        repeat (8) @(negedge clk);
        wb(1'b1, USD_OFS_DATA, 32'h3c);
        wb(1'b1, USD_OFS_DATA, 32'hc3);
        wb(1'b1, USD_OFS_CONTROL, 32'h0);
        `CHK("tx_hold", 2'b10, {oe, own})
        wb(1'b0, USD_OFS_STATUS, 32'h0);
        `CHK("flush", 2'b00, {rd[7], rd[5]})
        st.run('1, 2 * len + 2, got);
        repeat (8) @(negedge clk);
        off = got[len] ? len + 1 : len;
        `CHK("tx_last", 32'(frame(9'h0c3, f, 1'b0, 1'b0)) & mk, (got >> off) & mk)
        `CHK("oe_off", 2'b01, {oe, sdo})
        conclude;
    end
endmodule // testbench

// *** test/usd_station.sv ***
// Remote synchronous serial station clocking the link.
`timescale 1ns/10ps
module usd_station (
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    // Clock rests low between frames; the data line idles high.
    initial begin
        sck = 1'b0;
        sdi = 1'b1;
    end
    task automatic run(input logic [31:0] bits, input int n,
                       output logic [31:0] got);
        got = '1;
        #7;
        for (int i = 0; i < n; i++) begin
            sck = 1'b1;
            #20 sdi = bits[i];
            #140 sck = 1'b0;
            #160 got[i] = sdo;
        end
        sdi = 1'b1;
    endtask
endmodule // usd_station

// *** test/usd_sva.sv ***
// Port assertions for the USART data path.
`timescale 1ns/10ps
module usd_sva (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic WB_ACK_O,
    input wire logic SERIAL_CLOCK_PIN,
    input wire logic SERIAL_OUT_PIN,
    input wire logic SERIAL_OUT_OE,
    input wire logic SERIAL_IN_OWNED,
    input wire logic TXC_IRQ_TAKEN,
    input wire logic IRQ_TX_EMPTY,
    input wire logic IRQ_TX_DONE,
    input wire logic IRQ_RX_DONE
);
    logic       sck_q;
    logic [3:0] age_q;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    always_ff @(posedge CLK_SYS) begin
        sck_q <= SERIAL_CLOCK_PIN;
    end
    // Cycles since the last rising link clock; saturates when idle.
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            age_q <= 4'hf;
        end else if (SERIAL_CLOCK_PIN && !sck_q) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end
    AST_ACK_LAT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
        |=> WB_ACK_O) else $error("ack late");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    AST_EMPTY_DROP: assert property ($fell(IRQ_TX_EMPTY)
        |-> $past(WB_ACK_O && WB_WE_I)) else $error("empty fell alone");
    AST_EMPTY_HOLD: assert property (IRQ_TX_EMPTY && !WB_CYC_I
        |=> IRQ_TX_EMPTY) else $error("empty request lost");
    AST_DONE_IDLE: assert property ($rose(IRQ_TX_DONE)
        |-> SERIAL_OUT_PIN) else $error("done mid frame");
    AST_DONE_TAKEN: assert property (TXC_IRQ_TAKEN && IRQ_TX_DONE
        |=> !IRQ_TX_DONE) else $error("done not cleared");
    AST_OE_IDLE: assert property ($fell(SERIAL_OUT_OE)
        |-> $past(SERIAL_OUT_PIN) && SERIAL_OUT_PIN) else $error("oe cut");
    AST_IDLE_HIGH: assert property (!SERIAL_OUT_OE |-> SERIAL_OUT_PIN)
        else $error("pin low unowned");
    AST_TX_PACE: assert property ($changed(SERIAL_OUT_PIN)
        |-> age_q <= 4'h6) else $error("tx bit off clock");
    AST_OWN_WRITE: assert property ($changed(SERIAL_IN_OWNED)
        |-> $past(WB_ACK_O && WB_WE_I)) else $error("own w/o write");
    AST_RX_OWN: assert property (IRQ_RX_DONE |-> SERIAL_IN_OWNED)
        else $error("rx flag while off");
    COV_WRITE: cover property (WB_ACK_O && WB_WE_I);
    COV_RX: cover property ($rose(IRQ_RX_DONE));
    COV_OE_OFF: cover property ($fell(SERIAL_OUT_OE));
endmodule // usd_sva
bind usd_core usd_sva u_sva (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ACK_O(WB_ACK_O),
    .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
    .SERIAL_OUT_OE(SERIAL_OUT_OE), .SERIAL_IN_OWNED(SERIAL_IN_OWNED),
    .TXC_IRQ_TAKEN(TXC_IRQ_TAKEN), .IRQ_TX_EMPTY(IRQ_TX_EMPTY),
    .IRQ_TX_DONE(IRQ_TX_DONE), .IRQ_RX_DONE(IRQ_RX_DONE));
